// >>> logic/ebrr_defines.vh
// Constants for the external bus ready-on-read sequencer.
`ifndef EBRR_DEFINES_VH
`define EBRR_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the Wishbone bus)
// ----------------------------------------------------------------------------
`define EBRR_OFF_CONFIG 8'h00
`define EBRR_OFF_ADDR 8'h04
`define EBRR_OFF_STATUS 8'h08
`define EBRR_OFF_DATA 8'h0c

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define EBRR_CFG_LEAD_LSB 0
`define EBRR_CFG_LEAD_MSB 1
`define EBRR_CFG_ACT_LSB 2
`define EBRR_CFG_ACT_MSB 4
`define EBRR_CFG_TRAIL_LSB 5
`define EBRR_CFG_TRAIL_MSB 6
`define EBRR_CFG_RDY_EN 7
`define EBRR_CFG_RDY_ASYNC 8
`define EBRR_CFG_DOUBLE 9
`define EBRR_CFG_BUS32 10
`define EBRR_CFG_W 11
`define EBRR_CFG_RESET 11'h47f

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define EBRR_ST_BUSY 0
`define EBRR_ST_DONE 1
`define EBRR_ST_ALIGNED 2
`define EBRR_ST_ODD 3
`define EBRR_ST_WAIT_LSB 8
`define EBRR_ST_WAIT_MSB 15

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define EBRR_CLK_NS 5
`define EBRR_TIM_NS 20
`define EBRR_TIM_DIV (`EBRR_TIM_NS / `EBRR_CLK_NS)
`define EBRR_ADDR_RESET 20'hfffff

`endif

// >>> logic/ebrr_data_reg.v
// Read data capture register for the external bus.
`timescale 1ns/1ps
`default_nettype none

module ebrr_data_reg (
  input wire clk_i,
  input wire rst_i,
  input wire cap_i,
  input wire bus32_i,
  input wire [31:0] d_i,
  output reg [31:0] q_o
);

  // In 16-bit mode the upper lanes are not driven by the far side.
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 32'h0000_0000;
    end else if (cap_i) begin
      q_o <= bus32_i ? d_i : {16'h0000, d_i[15:0]};
    end
  end

endmodule // ebrr_data_reg

`default_nettype wire

// >>> logic/ebrr_top.v
// External bus read sequencer with ready-stretched accesses and a Wishbone slave.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ebrr_defines.vh"

module ebrr_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg ext_bus_clock_out_o,
  output reg [19:0] ext_address_o,
  output reg zone_select_n_o,
  output reg read_strobe_n_o,
  output reg lower_write_strobe_n_o,
  output reg upper_write_strobe_n_o,
  output reg read_write_dir_o,
  input wire [31:0] ext_data_bus_i,
  input wire ext_ready_in_i
);

  // --------------------------------------------------------------------------
  // Constants and helpers
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ALIGN = 3'd1;
  localparam [2:0] ST_LEAD = 3'd2;
  localparam [2:0] ST_ACTIVE = 3'd3;
  localparam [2:0] ST_TRAIL = 3'd4;
  localparam integer TIM_DIV = `EBRR_TIM_DIV;
  localparam [2:0] DIV_LAST = TIM_DIV[2:0] - 3'd1;
  localparam [2:0] DIV_HALF = TIM_DIV[3:1];
  function hit;
    input [7:0] adr;
    input [7:0] off;
    hit = (adr == off);
  endfunction
  // At least one timing period per lead and active phase keeps the counters simple.
  function [2:0] at_least_one;
    input [2:0] n;
    at_least_one = (n == 3'd0) ? 3'd1 : n;
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [`EBRR_CFG_W-1:0] cfg_reg;
  reg [19:0] addr_reg;
  reg [7:0] wait_reg, ext_cnt_reg;
  reg [2:0] state_reg, state_next, div_reg, pcnt_reg, pcnt_next;
  reg [1:0] rdy_hist_reg;
  reg [31:0] dat_meta_reg, dat_sync_reg;
  reg pend_reg, done_reg, aligned_reg, phase_reg, rdy_meta_reg, rdy_sync_reg, cap, finish;
  wire [31:0] rd_data;
  wire [2:0] div_next, lead_n, act_n, trail_n;
  wire tick, phase_next, wb_req, wb_wr, rdy_en, rdy_async, dbl, bus32, ready_seen, act_end, start_req, odd_total;
  assign lead_n = at_least_one({1'b0, cfg_reg[`EBRR_CFG_LEAD_MSB:`EBRR_CFG_LEAD_LSB]});
  assign act_n = at_least_one(cfg_reg[`EBRR_CFG_ACT_MSB:`EBRR_CFG_ACT_LSB]);
  assign trail_n = {1'b0, cfg_reg[`EBRR_CFG_TRAIL_MSB:`EBRR_CFG_TRAIL_LSB]};
  assign rdy_en = cfg_reg[`EBRR_CFG_RDY_EN];
  assign rdy_async = cfg_reg[`EBRR_CFG_RDY_ASYNC];
  assign dbl = cfg_reg[`EBRR_CFG_DOUBLE];
  assign bus32 = cfg_reg[`EBRR_CFG_BUS32];
  assign odd_total = lead_n[0] ^ act_n[0] ^ trail_n[0];

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdy_meta_reg <= 1'b0;
      rdy_sync_reg <= 1'b0;
      dat_meta_reg <= 32'h0000_0000;
      dat_sync_reg <= 32'h0000_0000;
    end else begin
      rdy_meta_reg <= ext_ready_in_i;
      rdy_sync_reg <= rdy_meta_reg;
      dat_meta_reg <= ext_data_bus_i;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Timing clock and bus clock
  // --------------------------------------------------------------------------
  assign tick = (div_reg == DIV_LAST);
  assign div_next = tick ? 3'd0 : div_reg + 3'd1;
  // With the double setting the bus clock runs at half the timing rate, so an access can fall on either half.
  assign phase_next = (tick && dbl) ? ~phase_reg : (dbl ? phase_reg : 1'b0);

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 3'd0;
      phase_reg <= 1'b0;
      ext_bus_clock_out_o <= 1'b1;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
      ext_bus_clock_out_o <= dbl ? ~phase_next : (div_next < DIV_HALF);
    end
  end

  // --------------------------------------------------------------------------
  // Ready sampling
  // --------------------------------------------------------------------------
  // ready mode select
  // async sample taken two periods early
  // sync sample at lead plus active
  assign ready_seen = rdy_async ? rdy_hist_reg[1] : rdy_sync_reg;
  assign act_end = (pcnt_reg == 3'd1) && (!rdy_en || ready_seen);

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdy_hist_reg <= 2'b00;
    end else if (tick) begin
      rdy_hist_reg <= {rdy_hist_reg[0], rdy_sync_reg};
    end
  end

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  assign start_req = pend_reg && (state_reg == ST_IDLE);
  always @* begin
    state_next = state_reg;
    pcnt_next = pcnt_reg;
    cap = 1'b0;
    finish = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (pend_reg) begin
          if (dbl && phase_next) begin
            state_next = ST_ALIGN;
          end else begin
            state_next = ST_LEAD;
            pcnt_next = lead_n;
          end
        end
      end
      ST_ALIGN: begin
        state_next = ST_LEAD;
        pcnt_next = lead_n;
      end
      ST_LEAD: begin
        if (pcnt_reg == 3'd1) begin
          state_next = ST_ACTIVE;
          pcnt_next = act_n;
        end else begin
          pcnt_next = pcnt_reg - 3'd1;
        end
      end
      ST_ACTIVE: begin
        if (act_end) begin
          cap = 1'b1;
          if (trail_n == 3'd0) begin
            state_next = ST_IDLE;
            finish = 1'b1;
          end else begin
            state_next = ST_TRAIL;
            pcnt_next = trail_n;
          end
        end else if (pcnt_reg != 3'd1) begin
          pcnt_next = pcnt_reg - 3'd1;
        end
      end
      ST_TRAIL: begin
        if (pcnt_reg == 3'd1) begin
          state_next = ST_IDLE;
          finish = 1'b1;
        end else begin
          pcnt_next = pcnt_reg - 3'd1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      pcnt_reg <= 3'd0;
      ext_cnt_reg <= 8'h00;
    end else if (tick) begin
      state_reg <= state_next;
      pcnt_reg <= pcnt_next;
      if (start_req) begin
        ext_cnt_reg <= 8'h00;
      end else if (state_reg == ST_ACTIVE && pcnt_reg == 3'd1 && !act_end && ext_cnt_reg != 8'hff) begin
        ext_cnt_reg <= ext_cnt_reg + 8'h01;
      end
    end
  end

  // capture as the read strobe rises
  ebrr_data_reg u_data (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cap_i(tick && cap),
    .bus32_i(bus32),
    .d_i(dat_sync_reg),
    .q_o(rd_data)
  );

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_address_o <= `EBRR_ADDR_RESET;
      zone_select_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      lower_write_strobe_n_o <= 1'b1;
      upper_write_strobe_n_o <= 1'b1;
      read_write_dir_o <= 1'b1;
    end else if (tick) begin
      // zone select low for the read
      zone_select_n_o <= ~(state_next == ST_LEAD || state_next == ST_ACTIVE || state_next == ST_TRAIL);
      // read strobe in active phase only
      read_strobe_n_o <= ~(state_next == ST_ACTIVE);
      if (state_next == ST_LEAD && state_reg != ST_LEAD) begin
        ext_address_o <= addr_reg;
      end else if (state_next == ST_IDLE || state_next == ST_ALIGN) begin
        ext_address_o <= {ext_address_o[19:1], 1'b1};
      end
      if (bus32) begin
        upper_write_strobe_n_o <= 1'b1;
      end else if (state_next == ST_LEAD && state_reg != ST_LEAD) begin
        upper_write_strobe_n_o <= addr_reg[0];
      end else if (state_next == ST_IDLE || state_next == ST_ALIGN) begin
        upper_write_strobe_n_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  // Every access is answered one cycle after it is seen; unmapped reads give zero, unmapped writes are dropped.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (hit(wb_adr_i, `EBRR_OFF_CONFIG)) begin
          wb_dat_o <= {21'h00000, cfg_reg};
        end else if (hit(wb_adr_i, `EBRR_OFF_ADDR)) begin
          wb_dat_o <= {12'h000, addr_reg};
        end else if (hit(wb_adr_i, `EBRR_OFF_STATUS)) begin
          wb_dat_o <= {16'h0000, wait_reg, 4'h0, odd_total, aligned_reg, done_reg, pend_reg};
        end else if (hit(wb_adr_i, `EBRR_OFF_DATA)) begin
          wb_dat_o <= rd_data;
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // Writing the address starts a read; a write while busy is ignored so the
  // address on the pins cannot change under a running access.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `EBRR_CFG_RESET;
      addr_reg <= `EBRR_ADDR_RESET;
      pend_reg <= 1'b0;
      done_reg <= 1'b0;
      aligned_reg <= 1'b0;
      wait_reg <= 8'h00;
    end else begin
      if (wb_wr && hit(wb_adr_i, `EBRR_OFF_CONFIG) && !pend_reg) begin
        if (wb_sel_i[0]) begin
          cfg_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          cfg_reg[`EBRR_CFG_W-1:8] <= wb_dat_i[`EBRR_CFG_W-1:8];
        end
      end
      if (wb_wr && hit(wb_adr_i, `EBRR_OFF_ADDR) && !pend_reg && wb_sel_i == 4'hf) begin
        addr_reg <= wb_dat_i[19:0];
        pend_reg <= 1'b1;
      end else if (tick && finish) begin
        pend_reg <= 1'b0;
      end
      if (tick && state_reg == ST_ALIGN) begin
        aligned_reg <= 1'b1;
      end else if (tick && start_req) begin
        aligned_reg <= 1'b0;
      end
      // Completion wins over a clear arriving in the same cycle.
      if (tick && finish) begin
        done_reg <= 1'b1;
        wait_reg <= ext_cnt_reg;
      end else if (wb_wr && hit(wb_adr_i, `EBRR_OFF_STATUS) && wb_sel_i[0] && wb_dat_i[`EBRR_ST_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

endmodule // ebrr_top

`default_nettype wire

// >>> verif/ebrr_top_monitor.sv
// Port checker for the external bus read sequencer.
`timescale 1ns/1ps
`default_nettype none
module ebrr_top_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire ext_bus_clock_out_o,
  input wire [19:0] ext_address_o,
  input wire zone_select_n_o,
  input wire read_strobe_n_o,
  input wire lower_write_strobe_n_o,
  input wire upper_write_strobe_n_o,
  input wire read_write_dir_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A lead or active phase lasts at least one timing period of four clocks.
  sequence lead_s;
    read_strobe_n_o [*4];
  endsequence
  sequence act_s;
    !read_strobe_n_o [*4];
  endsequence
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  lead_edge_a: assert property ($fell(zone_select_n_o) |-> ext_bus_clock_out_o ##0 lead_s)
    else $error("access start misplaced");
  idle_addr_a: assert property (zone_select_n_o |-> ext_address_o[0]) else $error("idle bit zero low");
  strobe_zone_a: assert property (!read_strobe_n_o |-> !zone_select_n_o) else $error("strobe outside zone");
  active_len_a: assert property ($fell(read_strobe_n_o) |-> act_s) else $error("active phase short");
  addr_hold_a: assert property (!zone_select_n_o && !$past(zone_select_n_o) |-> $stable(ext_address_o))
    else $error("address moved in access");
  ctrl_idle_a: assert property (zone_select_n_o |-> upper_write_strobe_n_o && lower_write_strobe_n_o
    && read_write_dir_o) else $error("control active while idle");
endmodule // ebrr_top_monitor
bind ebrr_top ebrr_top_monitor u_ebrr_top_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .ext_bus_clock_out_o, .ext_address_o, .zone_select_n_o, .read_strobe_n_o, .lower_write_strobe_n_o,
  .upper_write_strobe_n_o, .read_write_dir_o);
`default_nettype wire

// >>> verif/ebrr_mem_model.sv
// Far-side memory that answers reads and stretches them with ready.
`timescale 1ns/1ps
`default_nettype none
module ebrr_mem_model (
  input wire logic clk_i,
  input wire logic zone_n_i,
  input wire logic rd_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wait_i,
  output logic [31:0] data_o = 32'h0,
  output logic ready_o = 1'b0
);
  logic [7:0] cnt = 8'h0;
  always @(posedge clk_i) begin
    if (zone_n_i) begin
      cnt <= 8'h0;
      ready_o <= 1'b0;
      // Released bus toggles so a late capture cannot look valid.
      data_o <= ~data_o;
    end else begin
      data_o <= {addr_i[11:0], addr_i} ^ 32'ha5a50000;
      if (!rd_n_i && cnt < wait_i)
        cnt <= cnt + 8'h1;
      ready_o <= ready_o | (!rd_n_i && cnt >= wait_i);
    end
  end
endmodule // ebrr_mem_model
`default_nettype wire

// >>> verif/ext_bus_ready_read_tb_top.sv
// Self-checking bench for the external bus read sequencer.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ready_read_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, waits = 0, w;
  logic [31:0] wdat = 0, rdat, st, r, ext_d, seed = 32'h096c;
  logic [10:0] cfg;
  logic [2:0] a;
  logic ext_rdy;
  int failures = 0, compares = 0, i;
  wire [31:0] wb_dat_o;
  wire [19:0] xa;
  wire wb_ack_o, bclk, zone_n, rd_n, lwe_n, uwe_n, rw;
  always #2.5 clk_i = ~clk_i;
  ebrr_top u_ebrr_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .ext_bus_clock_out_o(bclk), .ext_address_o(xa),
    .zone_select_n_o(zone_n), .read_strobe_n_o(rd_n), .lower_write_strobe_n_o(lwe_n),
    .upper_write_strobe_n_o(uwe_n), .read_write_dir_o(rw), .ext_data_bus_i(ext_d), .ext_ready_in_i(ext_rdy));
  ebrr_mem_model u_ebrr_mem_model (.clk_i, .zone_n_i(zone_n), .rd_n_i(rd_n), .addr_i(xa), .wait_i(waits),
    .data_o(ext_d), .ready_o(ext_rdy));
  task print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= wr; adr <= ad; wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 0; stb <= 0;
  endtask
  function logic [31:0] mdat(input logic [19:0] ad, input logic b32);
    mdat = ({ad[11:0], ad} ^ 32'ha5a50000) & (b32 ? 32'hffffffff : 32'h0000ffff);
  endfunction
  // A ready already high at the first sample needs no extension; async looks two periods back.
  function logic [31:0] ext_exp(input logic [10:0] c, input logic [7:0] wt);
    ext_exp = {31'h0, c[7] && (wt != 8'h00 || (c[8] && c[4:2] < 3'd3))};
  endfunction
  // Lead and active of zero count as one period, a trail of zero as none.
  function logic [31:0] odd_exp(input logic [10:0] c);
    odd_exp = {31'h0, (c[1:0] == 2'h0 || c[0]) ^ (c[4:2] == 3'h0 || c[2]) ^ c[5]};
  endfunction
  // Runs one read and checks pins, data and whether the ready extension count is zero.
  task acc(input logic [10:0] c, input logic [19:0] ad, input logic [7:0] wt);
    waits <= wt;
    wb(1, 8'h00, {21'h0, c});
    wb(1, 8'h04, {12'h0, ad});
    while (zone_n !== 1'b0) begin
      @(posedge clk_i);
    end
    chk({31'h0, uwe_n}, {31'h0, c[10] | ad[0]});
    chk({12'h0, xa}, {12'h0, ad});
    do begin
      wb(0, 8'h08, 0);
    end while (rdat[1] !== 1'b1);
    st = rdat;
    wb(1, 8'h08, 32'h2);
    wb(0, 8'h0c, 0);
    chk(rdat, mdat(ad, c[10]));
    chk({12'h0, xa}, {12'h0, ad[19:1], 1'b1});
    chk({31'h0, st[3]}, odd_exp(c));
    if (!c[7])
      chk({24'h0, st[15:8]}, 32'h0);
    else
      chk({31'h0, |st[15:8]}, ext_exp(c, wt));
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    chk(rdat, 32'h47f);
    chk({12'h0, xa}, 32'hfffff);
    wb(1, 8'h10, 32'hffffffff);
    wb(0, 8'h10, 0);
    chk(rdat, 32'h0);
    wb(0, 8'h00, 0);
    chk(rdat, 32'h47f);
    acc(11'h425, 20'h12345, 8'hff);
    acc(11'h07f, 20'habcd1, 8'h00);
    acc(11'h625, 20'h00fff, 8'h00);
    acc(11'h0a5, 20'h5a5a4, 8'h00);
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      a = (r[4:2] == 0) ? 3'h1 : r[4:2];
      cfg = {r[10:8], 1'b1, r[6:0]};
      w = {3'h0, a, 2'h0} + 8'h08 + {4'h0, r[15:12]};
      acc(cfg, r[31:12], w);
    end
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    print_verdict;
  end
endmodule // ext_bus_ready_read_tb_top
`default_nettype wire
